// *** design/spp_top.sv ***
// Storage and pulse primitives: latch, delay flop, gate latches, one-shot, oscillator, edge input, inverter
// How it works
// R1: With enable active, the latch sets on true data and clears on false data.
// R2: With enable active, latch outputs follow every data change each clock.
// R3: With enable inactive, the latch holds its state and ignores data.
// R4: With inverted enable, the latch is transparent while enable is false.
// R5: The delay flop takes its data only at the clock edge.
// R6: The nand latch sets on any low set input, clears on any low clear.
// R7: Surrounding logic keeps all nand latch inputs high when idle.
// R8: The nor latch sets on a high set, clears on a high clear.
// R9: Set and clear together drive both gate latch outputs true.
// R10: After set and clear overlap, the request released last decides the state.
// R11: The one-shot goes active on a trigger and ends after a fixed count.
// R12: The one-shot fires on a rising input, or falling when inverted.
// R13: The oscillator drives two complementary outputs with set phase widths.
// R14: Non-inverted control: runs while true, rests clear while stopped.
// R15: Inverted control: runs while false, rests set while stopped.
// R16: High and low phase lengths are independent.
// R17: The edge input responds only to a level change.
// R18: The inverting buffer drives the complement of its input.
// R19: Interval and phase lengths are parameters in ref_clk cycles.
// R20: Edges are found by comparing a registered previous value to the current one.
`timescale 1ns/100ps
`include "spp_cfg.svh"

module spp_top #(
  parameter int                    CW        = `SPP_CNT_W,
  parameter bit                    LAT_INV   = 1'b0,
  parameter bit                    OS_INV    = 1'b0,
  parameter bit                    CTRL_INV  = 1'b0,
  parameter logic [`SPP_CNT_W-1:0] OS_CYCLES = `SPP_OS_CYCLES,
  parameter logic [`SPP_CNT_W-1:0] OSC_HI    = `SPP_OSC_HI,
  parameter logic [`SPP_CNT_W-1:0] OSC_LO    = `SPP_OSC_LO
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Transparent latch
  input  wire logic lat_en,
  input  wire logic lat_d,
  output logic      lat_q,
  output logic      lat_qn,
  // Delay flop
  input  wire logic dff_d,
  output logic      dff_q,
  // Nand gate latch, active-low inputs
  input  wire logic nand_set_a_n,
  input  wire logic nand_set_b_n,
  input  wire logic nand_clr_a_n,
  input  wire logic nand_clr_b_n,
  output logic      nand_q,
  output logic      nand_qn,
  // Nor gate latch
  input  wire logic nor_set,
  input  wire logic nor_clr,
  output logic      nor_q,
  output logic      nor_qn,
  // One-shot
  input  wire logic os_trig,
  output logic      os_q,
  output logic      os_qn,
  // Gated pulse oscillator
  input  wire logic osc_ctrl,
  output logic      gated_pulse_oscillator_q,
  output logic      gated_pulse_oscillator_qn,
  // Edge-coupled input
  input  wire logic edge_in,
  output logic      edge_pulse,
  // Inverting buffer
  input  wire logic inv_in,
  output logic      inv_out
);

  localparam logic [CW-1:0] OS_LAST = CW'(OS_CYCLES - `SPP_CNT_STEP);
  localparam logic [CW-1:0] HI_LAST = CW'(OSC_HI - `SPP_CNT_STEP);
  localparam logic [CW-1:0] LO_LAST = CW'(OSC_LO - `SPP_CNT_STEP);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ****************************************
  // Transparent latch
  // ****************************************
  logic lat_open;

  assign lat_open = lat_en ^ LAT_INV;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lat_q  <= `SPP_RST_LO;
      lat_qn <= `SPP_RST_HI;
    end else if (lat_open) begin
      lat_q  <= lat_d;   // [R1] [R2] [R4]
      lat_qn <= ~lat_d;
    end
  end

  a_latch_follow: assert property (lat_open |=> lat_q == $past(lat_d) && lat_qn != lat_q) // [R1] [R2] [R4]
    else $error("latch did not follow data while open");

  a_latch_hold: assert property (!lat_open |=> $stable(lat_q) && $stable(lat_qn)) // [R3]
    else $error("latch changed while closed");

  // ****************************************
  // Delay flop
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dff_q <= `SPP_RST_LO;
    end else begin
      dff_q <= dff_d;   // [R5]
    end
  end

  a_dff_capture: assert property (##1 dff_q == $past(dff_d)) // [R5]
    else $error("delay flop did not take data at the edge");

  // ****************************************
  // Gate latches: index 0 nand, index 1 nor
  // ****************************************
  spp_pkg::spp_pair_t gl_set;
  spp_pkg::spp_pair_t gl_clr;
  spp_pkg::spp_pair_t gl_state;
  spp_pkg::spp_pair_t gl_q;
  spp_pkg::spp_pair_t gl_qn;

  // Idle nand inputs are high, so only a low input acts
  assign gl_set[0] = ~(nand_set_a_n & nand_set_b_n);   // [R6] [R7]
  assign gl_clr[0] = ~(nand_clr_a_n & nand_clr_b_n);   // [R6] [R7]
  assign gl_set[1] = nor_set;                          // [R8]
  assign gl_clr[1] = nor_clr;                          // [R8]

  for (genvar g = 0; g < 2; g++) begin : g_gate
    // State moves only on a lone request, so the one released last wins
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        gl_state[g] <= `SPP_RST_LO;
      end else if (gl_set[g] && !gl_clr[g]) begin
        gl_state[g] <= `SPP_RST_HI;   // [R10]
      end else if (gl_clr[g] && !gl_set[g]) begin
        gl_state[g] <= `SPP_RST_LO;   // [R10]
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        gl_q[g]  <= `SPP_RST_LO;
        gl_qn[g] <= `SPP_RST_HI;
      end else if (gl_set[g] && gl_clr[g]) begin
        gl_q[g]  <= `SPP_RST_HI;   // [R9]
        gl_qn[g] <= `SPP_RST_HI;
      end else if (gl_set[g]) begin
        gl_q[g]  <= `SPP_RST_HI;   // [R6] [R8]
        gl_qn[g] <= `SPP_RST_LO;
      end else if (gl_clr[g]) begin
        gl_q[g]  <= `SPP_RST_LO;   // [R6] [R8]
        gl_qn[g] <= `SPP_RST_HI;
      end else begin
        gl_q[g]  <= gl_state[g];   // [R10]
        gl_qn[g] <= ~gl_state[g];
      end
    end
  end

  assign nand_q  = gl_q[0];
  assign nand_qn = gl_qn[0];
  assign nor_q   = gl_q[1];
  assign nor_qn  = gl_qn[1];

  a_nand_set: assert property (gl_set[0] && !gl_clr[0] |=> nand_q && !nand_qn) // [R6]
    else $error("nand latch did not set");

  a_nor_clear: assert property (nor_clr && !nor_set |=> !nor_q && nor_qn) // [R8]
    else $error("nor latch did not clear");

  a_gate_both: assert property (gl_set[0] && gl_clr[0] |=> nand_q && nand_qn) // [R9]
    else $error("nand latch outputs not both true on overlap");

  a_gate_last: assert property (nor_set && nor_clr ##1 nor_set && !nor_clr ##1 !nor_set && !nor_clr |=> nor_q && !nor_qn) // [R10]
    else $error("nor latch did not settle to the last released request");

  // ****************************************
  // One-shot
  // ****************************************
  spp_pkg::spp_os_state_t os_state;
  logic                   os_prev;
  logic                   os_fire;
  logic [CW-1:0]          os_cnt;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      os_prev <= `SPP_RST_LO;
    end else begin
      os_prev <= os_trig;   // [R20]
    end
  end

  // Rising edge by default, falling when inverted
  assign os_fire = OS_INV ? (os_prev && !os_trig) : (!os_prev && os_trig);   // [R12] [R20]

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      os_state <= spp_pkg::SPP_OS_IDLE;
      os_cnt   <= `SPP_CNT_ZERO;
      os_q     <= `SPP_RST_LO;
      os_qn    <= `SPP_RST_HI;
    end else begin
      case (os_state)
        spp_pkg::SPP_OS_IDLE: begin
          os_cnt <= `SPP_CNT_ZERO;
          if (os_fire) begin
            os_state <= spp_pkg::SPP_OS_PULSE;   // [R11]
            os_q     <= `SPP_RST_HI;
            os_qn    <= `SPP_RST_LO;
          end
        end
        spp_pkg::SPP_OS_PULSE: begin
          // Triggers during the pulse are ignored
          if (os_cnt == OS_LAST) begin
            os_state <= spp_pkg::SPP_OS_IDLE;    // [R11] [R19]
            os_cnt   <= `SPP_CNT_ZERO;
            os_q     <= `SPP_RST_LO;
            os_qn    <= `SPP_RST_HI;
          end else begin
            os_cnt <= os_cnt + `SPP_CNT_STEP;
          end
        end
        default: begin
          os_state <= spp_pkg::SPP_OS_IDLE;
          os_q     <= `SPP_RST_LO;
          os_qn    <= `SPP_RST_HI;
        end
      endcase
    end
  end

  a_os_start: assert property (os_fire && !os_q |=> os_q && !os_qn) // [R11] [R12]
    else $error("one-shot did not start on a trigger edge");

  a_os_width: assert property (os_q && os_cnt == OS_LAST |=> !os_q && os_qn) // [R11] [R19]
    else $error("one-shot did not end after its interval");

  a_os_count: assert property (os_q |-> os_cnt <= OS_LAST) // [R19]
    else $error("one-shot ran past its interval");

  // ****************************************
  // Gated pulse oscillator
  // ****************************************
  logic          osc_run;
  logic          osc_q;
  logic          osc_qn;
  logic [CW-1:0] osc_cnt;

  assign osc_run = osc_ctrl ^ CTRL_INV;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_q   <= CTRL_INV;
      osc_qn  <= ~CTRL_INV;
      osc_cnt <= `SPP_CNT_ZERO;
    end else if (!osc_run) begin
      osc_q   <= CTRL_INV;    // [R14] [R15]
      osc_qn  <= ~CTRL_INV;
      osc_cnt <= `SPP_CNT_ZERO;
    end else if (osc_cnt == (osc_q ? HI_LAST : LO_LAST)) begin
      osc_q   <= ~osc_q;      // [R13] [R16] [R19]
      osc_qn  <= osc_q;
      osc_cnt <= `SPP_CNT_ZERO;
    end else begin
      osc_cnt <= osc_cnt + `SPP_CNT_STEP;
    end
  end

  assign gated_pulse_oscillator_q  = osc_q;
  assign gated_pulse_oscillator_qn = osc_qn;

  a_osc_comp: assert property (osc_q != osc_qn) // [R13]
    else $error("oscillator outputs not complementary");

  a_osc_rest: assert property (!osc_run |=> osc_q == CTRL_INV) // [R14] [R15]
    else $error("stopped oscillator not at its resting level");

  a_osc_high: assert property (osc_run && osc_q && osc_cnt == HI_LAST |=> !osc_q) // [R16] [R19]
    else $error("oscillator high phase length wrong");

  a_osc_low: assert property (osc_run && !osc_q && osc_cnt == LO_LAST |=> osc_q) // [R16] [R19]
    else $error("oscillator low phase length wrong");

  // ****************************************
  // Edge-coupled input and inverting buffer
  // ****************************************
  logic edge_prev;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edge_prev  <= `SPP_RST_LO;
      edge_pulse <= `SPP_RST_LO;
    end else begin
      edge_prev  <= edge_in;
      edge_pulse <= edge_in ^ edge_prev;   // [R17] [R20]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      inv_out <= `SPP_RST_HI;
    end else begin
      inv_out <= ~inv_in;   // [R18]
    end
  end

  a_edge_resp: assert property (##2 edge_pulse == ($past(edge_in) != $past(edge_in, 2))) // [R17] [R20]
    else $error("edge response does not match an input change");

  a_inv_buf: assert property (##1 inv_out == !$past(inv_in)) // [R18]
    else $error("inverting buffer output wrong");

endmodule

// *** design/spp_cfg.svh ***
// Constant values for the storage and pulse primitives
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// ****************************************
// Widths
// ****************************************
`define SPP_CNT_W      16

// ****************************************
// Default interval lengths in ref_clk cycles
// ****************************************
`define SPP_OS_CYCLES  16'h0008
`define SPP_OSC_HI     16'h0003
`define SPP_OSC_LO     16'h0005

// ****************************************
// Reset and resting values, counter step
// ****************************************
`define SPP_RST_LO     1'b0
`define SPP_RST_HI     1'b1
`define SPP_CNT_STEP   16'h0001
`define SPP_CNT_ZERO   16'h0000

`endif

// *** design/spp_pkg.sv ***
// Types shared by the storage and pulse primitives
package spp_pkg;

  typedef enum logic {
    SPP_OS_IDLE,
    SPP_OS_PULSE
  } spp_os_state_t;

  typedef logic [1:0] spp_pair_t;

endpackage

// *** verif/spp_tb.sv ***
// Self-checking testbench for the storage and pulse primitives
`timescale 1ns/100ps

module testbench;
  logic ref_clk = 1'b0, nrst = 1'b0;
  logic lat_en = 1'b0, lat_d = 1'b0, lat_q, lat_qn, dff_d = 1'b0, dff_q;
  logic nand_set_a_n = 1'b1, nand_set_b_n = 1'b1, nand_clr_a_n = 1'b1, nand_clr_b_n = 1'b1, nand_q, nand_qn;
  logic nor_set = 1'b0, nor_clr = 1'b0, nor_q, nor_qn, os_trig = 1'b0, os_q, os_qn;
  logic osc_ctrl = 1'b0, osc_q, osc_qn, edge_in = 1'b0, edge_pulse, inv_in = 1'b0, inv_out;
  logic lat_q_inv, lat_qn_inv, os_q_inv, os_qn_inv, osc_q_inv, osc_qn_inv;
  int   n_mismatch = 0;
  int   samples_checked = 0;
  int   n;

  always #20 ref_clk = ~ref_clk;

  spp_top i_spp_top (
    .ref_clk(ref_clk), .nrst(nrst), .lat_en(lat_en), .lat_d(lat_d), .lat_q(lat_q), .lat_qn(lat_qn),
    .dff_d(dff_d), .dff_q(dff_q), .nand_set_a_n(nand_set_a_n), .nand_set_b_n(nand_set_b_n),
    .nand_clr_a_n(nand_clr_a_n), .nand_clr_b_n(nand_clr_b_n), .nand_q(nand_q), .nand_qn(nand_qn),
    .nor_set(nor_set), .nor_clr(nor_clr), .nor_q(nor_q), .nor_qn(nor_qn), .os_trig(os_trig),
    .os_q(os_q), .os_qn(os_qn), .osc_ctrl(osc_ctrl), .gated_pulse_oscillator_q(osc_q),
    .gated_pulse_oscillator_qn(osc_qn), .edge_in(edge_in), .edge_pulse(edge_pulse),
    .inv_in(inv_in), .inv_out(inv_out)
  );

  // Second copy with every polarity option inverted
  spp_top #(.LAT_INV(1'b1), .OS_INV(1'b1), .CTRL_INV(1'b1)) i_spp_top_inv (
    .ref_clk(ref_clk), .nrst(nrst), .lat_en(lat_en), .lat_d(lat_d), .lat_q(lat_q_inv), .lat_qn(lat_qn_inv),
    .dff_d(dff_d), .dff_q(), .nand_set_a_n(nand_set_a_n), .nand_set_b_n(nand_set_b_n),
    .nand_clr_a_n(nand_clr_a_n), .nand_clr_b_n(nand_clr_b_n), .nand_q(), .nand_qn(),
    .nor_set(nor_set), .nor_clr(nor_clr), .nor_q(), .nor_qn(), .os_trig(os_trig),
    .os_q(os_q_inv), .os_qn(os_qn_inv), .osc_ctrl(osc_ctrl), .gated_pulse_oscillator_q(osc_q_inv),
    .gated_pulse_oscillator_qn(osc_qn_inv), .edge_in(edge_in), .edge_pulse(),
    .inv_in(inv_in), .inv_out()
  );

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // Length of the run of one level on the one-shot (0) or oscillator (1)
  task automatic run_len(input int s, input logic lvl, output int cnt);
    cnt = 0;
    while (((s == 0) ? os_q : osc_q) === lvl && cnt < 40) begin
      cnt++;
      tick(1);
    end
  endtask

  task automatic stop_test;
    $display("Checks: %0d, mismatches: %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk({lat_q, lat_qn, dff_q, nand_q, nand_qn, nor_q, nor_qn, os_q, os_qn}, 9'h095);
    chk({osc_q, osc_qn, edge_pulse, inv_out}, 4'h5);
    chk({osc_q_inv, osc_qn_inv}, 2'h2);
    $display("reset test done");
  endtask

  task automatic t_latch;
    lat_en = 1'b1; lat_d = 1'b1; tick(1);
    chk({lat_q, lat_qn}, 2'h2);
    lat_d = 1'b0; tick(1);
    chk({lat_q, lat_qn}, 2'h1);
    lat_en = 1'b0; lat_d = 1'b1; tick(2);
    chk({lat_q, lat_qn}, 2'h1);
    $display("latch test done");
  endtask

  task automatic t_dff;
    dff_d = 1'b1; #5;
    chk(dff_q, 1'b0);
    tick(1);
    chk(dff_q, 1'b1);
    dff_d = 1'b0; #5;
    chk(dff_q, 1'b1);
    tick(1);
    chk(dff_q, 1'b0);
    $display("delay flop test done");
  endtask

  task automatic t_gate;
    nand_set_b_n = 1'b0; tick(1); nand_set_b_n = 1'b1; tick(1);
    chk({nand_q, nand_qn}, 2'h2);
    nand_clr_b_n = 1'b0; tick(1); nand_clr_b_n = 1'b1; tick(1);
    chk({nand_q, nand_qn}, 2'h1);
    nand_set_a_n = 1'b0; nand_clr_a_n = 1'b0; tick(2);
    chk({nand_q, nand_qn}, 2'h3);
    nand_clr_a_n = 1'b1; tick(1); nand_set_a_n = 1'b1; tick(1);
    chk({nand_q, nand_qn}, 2'h2);
    nor_set = 1'b1; tick(1); nor_set = 1'b0; tick(1);
    chk({nor_q, nor_qn}, 2'h2);
    nor_clr = 1'b1; tick(1); nor_clr = 1'b0; tick(1);
    chk({nor_q, nor_qn}, 2'h1);
    nor_set = 1'b1; nor_clr = 1'b1; tick(2);
    chk({nor_q, nor_qn}, 2'h3);
    nor_set = 1'b0; tick(1); nor_clr = 1'b0; tick(1);
    chk({nor_q, nor_qn}, 2'h1);
    nor_set = 1'b1;
    nor_clr = 1'b1;
    tick(1);
    nor_clr = 1'b0;
    tick(1);
    nor_set = 1'b0;
    tick(1);
    chk({nor_q, nor_qn}, 2'h2);
    $display("gate latch test done");
  endtask

  task automatic t_oneshot;
    os_trig = 1'b1;
    run_len(0, 1'b0, n);
    chk(n, 16'h0001);
    chk({os_q, os_qn}, 2'h2);
    // Retrigger attempt in mid-pulse must not stretch it
    os_trig = 1'b0; tick(1); os_trig = 1'b1; tick(1);
    run_len(0, 1'b1, n);
    chk(n + 2, 16'h0008);
    tick(3);
    chk({os_q, os_qn}, 2'h1);
    os_trig = 1'b0; tick(4);
    chk(os_q, 1'b0);
    $display("one-shot test done");
  endtask

  task automatic t_osc;
    tick(3);
    chk({osc_q, osc_qn}, 2'h1);
    osc_ctrl = 1'b1;
    run_len(1, 1'b0, n);
    chk(n, 16'h0005);
    run_len(1, 1'b1, n);
    chk(n, 16'h0003);
    chk(osc_qn, 1'b1);
    run_len(1, 1'b0, n);
    chk(n, 16'h0005);
    chk(osc_qn, 1'b0);
    osc_ctrl = 1'b0; tick(2);
    chk({osc_q, osc_qn}, 2'h1);
    tick(8);
    chk({osc_q, osc_qn}, 2'h1);
    $display("oscillator test done");
  endtask

  task automatic t_edge;
    int k;
    for (int dir = 0; dir < 2; dir++) begin
      edge_in = ~edge_in;
      k = 0;
      repeat (6) begin
        tick(1);
        if (edge_pulse === 1'b1) k++;
      end
      chk(k, 16'h0001);
    end
    inv_in = 1'b0; tick(1);
    chk(inv_out, 1'b1);
    inv_in = 1'b1; tick(1);
    chk(inv_out, 1'b0);
    $display("edge and inverter test done");
  endtask

  task automatic t_inv;
    lat_d = 1'b0;
    tick(1);
    chk({lat_q_inv, lat_qn_inv}, 2'h1);
    lat_en = 1'b1;
    lat_d = 1'b1;
    tick(2);
    chk({lat_q_inv, lat_qn_inv}, 2'h1);
    lat_en = 1'b0;
    tick(1);
    chk({lat_q_inv, lat_qn_inv}, 2'h2);
    osc_ctrl = 1'b1;
    tick(2);
    chk({osc_q_inv, osc_qn_inv}, 2'h2);
    osc_ctrl = 1'b0;
    tick(2);
    chk({osc_q_inv, osc_qn_inv}, 2'h2);
    tick(1);
    chk({osc_q_inv, osc_qn_inv}, 2'h1);
    osc_ctrl = 1'b1;
    tick(2);
    chk({osc_q_inv, osc_qn_inv}, 2'h2);
    os_trig = 1'b1;
    tick(2);
    chk({os_q_inv, os_qn_inv}, 2'h1);
    os_trig = 1'b0;
    tick(1);
    chk({os_q_inv, os_qn_inv}, 2'h2);
    tick(7);
    chk(os_q_inv, 1'b1);
    tick(1);
    chk({os_q_inv, os_qn_inv}, 2'h1);
    $display("inverted polarity test done");
  endtask

  initial begin
    tick(5);
    t_reset();
    nrst = 1'b1;
    tick(1);
    t_latch();
    t_dff();
    t_gate();
    t_oneshot();
    t_osc();
    t_edge();
    t_inv();
    stop_test();
  end

  // Run needs about 110 cycles; allow far more
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
